// ### ifcr_top.sv
// Purpose: global interrupt control and request flag registers 0..2
// Assumes: request inputs are one-cycle pulses on mclk_in; pins async
// Notes:   read data appear in the cycle after the read strobe
// How it works
// - control bit 15 chooses alternate vector table when set
// - control bit 14 reads timed interrupt-disable status, read-only
// - control bits 2..0 pick negative edge when 1, positive when 0
// - control bits 13..3 read zero, writes ignored
// - every implemented bit except status bit 14 clears to zero at reset
// - flag register 0 low byte holds the listed eight sources
// - flag register 0 bits 14..8 hold listed sources, bit 15 zero
// - each flag reads 1 after its request, readable and writable
// - flag register 1 upper byte holds the listed eight sources
// - flag register 1 lower byte sources, bit 5 reads zero
// - flag register 2 sources at 14,13,4..0, others read zero
// - without CAN controller the CAN flags never get set
// - sources set flags; software clears them
// - each source has its own enable bit in enable registers
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "ifcr_defs.svh"

module ifcr_top
   import ifcr_pkg::*;
#(
   parameter bit CAN_PRESENT = 1'b1
)
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   // cpu core
   input  wire logic        timed_irq_disable_active_in,
   output logic             alt_vector_select_out,
   output logic             irq_out,
   // external interrupt pins 2..0
   input  wire logic [2:0]  ext_irq_pin_in,
   // requests landing in flag register 0
   input  wire logic        capture1_req_in,
   input  wire logic        compare1_req_in,
   input  wire logic        timer1_req_in,
   input  wire logic        dma_ch0_done_req_in,
   input  wire logic        capture2_req_in,
   input  wire logic        compare2_req_in,
   input  wire logic        timer2_req_in,
   input  wire logic        timer3_req_in,
   input  wire logic        spi1_error_req_in,
   input  wire logic        spi1_event_req_in,
   input  wire logic        uart1_receive_req_in,
   input  wire logic        uart1_transmit_req_in,
   input  wire logic        adc1_done_req_in,
   input  wire logic        dma_ch1_done_req_in,
   // requests landing in flag register 1
   input  wire logic        i2c1_slave_req_in,
   input  wire logic        i2c1_master_req_in,
   input  wire logic        comparator_req_in,
   input  wire logic        change_notify_req_in,
   input  wire logic        capture7_req_in,
   input  wire logic        capture8_req_in,
   input  wire logic        dma_ch2_done_req_in,
   input  wire logic        compare3_req_in,
   input  wire logic        compare4_req_in,
   input  wire logic        timer4_req_in,
   input  wire logic        timer5_req_in,
   input  wire logic        uart2_receive_req_in,
   input  wire logic        uart2_transmit_req_in,
   // requests landing in flag register 2
   input  wire logic        spi2_error_req_in,
   input  wire logic        spi2_event_req_in,
   input  wire logic        can_receive_req_in,
   input  wire logic        can_event_req_in,
   input  wire logic        dma_ch3_done_req_in,
   input  wire logic        parallel_port_req_in,
   input  wire logic        dma_ch4_done_req_in
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic        alt_vector_select_ff;
   logic [2:0]  ext_irq_polarity_ff;
   logic [2:0]  pin_meta_ff;
   logic [2:0]  pin_sync_ff;
   logic [2:0]  pin_prev_ff;
   logic [2:0]  ext_edge;
   logic        can_ok;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic [15:0] ctrl_word;
   logic [2:0]  irq_part;
   logic        wr_ctrl;

   ifcr_word_t  flag_ff [3];
   ifcr_word_t  en_ff   [3];
   ifcr_word_t  hw_set  [3];
   ifcr_word_t  flag_mask [3];

   // ----------------------------------------------------------------
   // global control register: vector table select
   // ----------------------------------------------------------------
   assign wr_ctrl = wr_in && (addr_in == `IFCR_CTRL_IDX);

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         alt_vector_select_ff <= `IFCR_RST_ALT;
      end
      else if (wr_ctrl)
      begin
         alt_vector_select_ff <= wdata_in[`IFCR_ALT_BIT];
      end
   end

   // vector fetch logic in the core follows this level
   assign alt_vector_select_out = alt_vector_select_ff;

   // ----------------------------------------------------------------
   // global control register: edge polarity
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         ext_irq_polarity_ff <= `IFCR_RST_POL;
      end
      else if (wr_ctrl)
      begin
         // bits 13..3 are not stored, so they read back as zero
         ext_irq_polarity_ff <= wdata_in[`IFCR_POL_LSB +: 3];
      end
   end

   // ----------------------------------------------------------------
   // global control register: read view
   // ----------------------------------------------------------------
   always_comb
   begin
      ctrl_word = `IFCR_RST_WORD;
      ctrl_word[`IFCR_ALT_BIT]      = alt_vector_select_ff;
      ctrl_word[`IFCR_TDIS_BIT]     = timed_irq_disable_active_in;
      ctrl_word[`IFCR_POL_LSB +: 3] = ext_irq_polarity_ff;
   end

   // ----------------------------------------------------------------
   // external pin synchronisers
   // ----------------------------------------------------------------
   // no reset: the chain follows the pins through reset, so a pin that
   // already sits at its selected level gives no false edge afterwards
   always_ff @(posedge mclk_in)
   begin
      pin_meta_ff <= ext_irq_pin_in;
      pin_sync_ff <= pin_meta_ff;
   end

   // ----------------------------------------------------------------
   // edge detectors
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      pin_prev_ff <= pin_sync_ff;
   end

   generate
      for (genvar p = 0; p < 3; p++)
      begin : g_edge
         // one-cycle pulse on the edge that the polarity bit selects
         assign ext_edge[p] = ext_irq_polarity_ff[p] ?
                              (pin_prev_ff[p] & ~pin_sync_ff[p]) :
                              (~pin_prev_ff[p] & pin_sync_ff[p]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // hardware request vectors, one per flag register
   // ----------------------------------------------------------------
   assign can_ok = CAN_PRESENT;

   assign hw_set[0] = {1'b0,
                       dma_ch1_done_req_in,
                       adc1_done_req_in,
                       uart1_transmit_req_in,
                       uart1_receive_req_in,
                       spi1_event_req_in,
                       spi1_error_req_in,
                       timer3_req_in,
                       timer2_req_in,
                       compare2_req_in,
                       capture2_req_in,
                       dma_ch0_done_req_in,
                       timer1_req_in,
                       compare1_req_in,
                       capture1_req_in,
                       ext_edge[0]};

   assign hw_set[1] = {uart2_transmit_req_in,
                       uart2_receive_req_in,
                       ext_edge[2],
                       timer5_req_in,
                       timer4_req_in,
                       compare4_req_in,
                       compare3_req_in,
                       dma_ch2_done_req_in,
                       capture8_req_in,
                       capture7_req_in,
                       1'b0,
                       ext_edge[1],
                       change_notify_req_in,
                       comparator_req_in,
                       i2c1_master_req_in,
                       i2c1_slave_req_in};

   assign hw_set[2] = {1'b0,
                       dma_ch4_done_req_in,
                       parallel_port_req_in,
                       8'h00,
                       dma_ch3_done_req_in,
                       can_event_req_in & can_ok,
                       can_receive_req_in & can_ok,
                       spi2_event_req_in,
                       spi2_error_req_in};

   // ----------------------------------------------------------------
   // implemented-bit masks; unimplemented bits never store a one
   // ----------------------------------------------------------------
   // the CAN slots drop out of register 2 when no controller is fitted
   assign flag_mask[0] = `IFCR_FLAG0_MASK;
   assign flag_mask[1] = `IFCR_FLAG1_MASK;
   assign flag_mask[2] = CAN_PRESENT ? `IFCR_FLAG2_MASK
                                     : `IFCR_FLAG2_MASK_NC;

   // ----------------------------------------------------------------
   // flag and enable registers
   // ----------------------------------------------------------------
   generate
      for (genvar k = 0; k < 3; k++)
      begin : g_reg
         logic       wr_flag;
         logic       wr_en;
         logic       wr_clr;
         ifcr_word_t nxt_flag;

         assign wr_flag = wr_in &&
                          (addr_in == 4'(`IFCR_FLAG0_IDX + k));
         assign wr_en   = wr_in &&
                          (addr_in == 4'(`IFCR_EN0_IDX + k));
         assign wr_clr  = wr_in &&
                          (addr_in == 4'(`IFCR_CLR0_IDX + k));

         always_comb
         begin
            nxt_flag = flag_ff[k] | hw_set[k];
            if (wr_flag)
            begin
               // written ones set, written zeros clear unless a request arrives in the same cycle
               nxt_flag = wdata_in | hw_set[k];
            end
            else if (wr_clr)
            begin
               nxt_flag = (flag_ff[k] & ~wdata_in) | hw_set[k];
            end
         end

         always_ff @(posedge mclk_in)
         begin
            if (rst_in)
            begin
               flag_ff[k] <= `IFCR_RST_WORD;
            end
            else
            begin
               flag_ff[k] <= nxt_flag & flag_mask[k];
            end
         end

         always_ff @(posedge mclk_in)
         begin
            if (rst_in)
            begin
               en_ff[k] <= `IFCR_RST_WORD;
            end
            else if (wr_en)
            begin
               en_ff[k] <= wdata_in & flag_mask[k];
            end
         end

         assign irq_part[k] = |(flag_ff[k] & en_ff[k]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // interrupt request output
   // ----------------------------------------------------------------
   // level request to the core while any enabled flag is set
   assign irq_out = |irq_part;

   // ----------------------------------------------------------------
   // read select
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_rdata = `IFCR_RST_WORD;
      if (rd_in)
      begin
         unique case (addr_in)
            `IFCR_CTRL_IDX:         nxt_rdata = ctrl_word;
            `IFCR_FLAG0_IDX:        nxt_rdata = flag_ff[0];
            `IFCR_FLAG1_IDX:        nxt_rdata = flag_ff[1];
            `IFCR_FLAG2_IDX:        nxt_rdata = flag_ff[2];
            `IFCR_EN0_IDX:          nxt_rdata = en_ff[0];
            `IFCR_EN1_IDX:          nxt_rdata = en_ff[1];
            `IFCR_EN2_IDX:          nxt_rdata = en_ff[2];
            // clear registers and holes read zero
            default:                nxt_rdata = `IFCR_RST_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read data register, holds a word for one cycle only
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         rdata_ff <= `IFCR_RST_WORD;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_out = rdata_ff;

endmodule : ifcr_top

// ### ifcr_defs.svh
// Purpose: register indices, field positions, masks and reset values
// Assumes: 4-bit register index on the plain register port
// Notes:   definitions only
`ifndef IFCR_DEFS_SVH
`define IFCR_DEFS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define IFCR_CTRL_IDX   4'h0
`define IFCR_FLAG0_IDX  4'h1
`define IFCR_FLAG1_IDX  4'h2
`define IFCR_FLAG2_IDX  4'h3
`define IFCR_EN0_IDX    4'h4
`define IFCR_EN1_IDX    4'h5
`define IFCR_EN2_IDX    4'h6
`define IFCR_CLR0_IDX   4'h8

// ----------------------------------------------------------------
// global control fields
// ----------------------------------------------------------------
`define IFCR_ALT_BIT    15
`define IFCR_TDIS_BIT   14
`define IFCR_POL_LSB    0
`define IFCR_CTRL_WMASK 16'h8007

// ----------------------------------------------------------------
// implemented flag bits per register
// ----------------------------------------------------------------
`define IFCR_FLAG0_MASK     16'h7fff
`define IFCR_FLAG1_MASK     16'hffdf
`define IFCR_FLAG2_MASK     16'h601f
`define IFCR_FLAG2_MASK_NC  16'h6013

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IFCR_RST_WORD   16'h0000
`define IFCR_RST_POL    3'h0
`define IFCR_RST_ALT    1'b0

`endif

// ### ifcr_pkg.sv
// Purpose: shared types of the interrupt flag and control slice
// Assumes: 16-bit registers
// Notes:   three flag registers, three enable registers
package ifcr_pkg;

   typedef logic [15:0] ifcr_word_t;
   typedef ifcr_word_t  ifcr_word3_t [3];

endpackage : ifcr_pkg

// ### ifcr_properties.sv
// Purpose: port-level checks of the flag and control slice
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into ifcr_top from the bench top file
`timescale 1ns/10ps
module ifcr_properties (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [15:0] rdata_out,
   // core and sources
   input  wire logic        timed_irq_disable_active_in,
   input  wire logic        alt_vector_select_out,
   input  wire logic        timer1_req_in
);
   logic [15:0] rsv_ff;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // bits that must read zero in the flag register being read
   always_ff @(posedge mclk_in)
   begin
      rsv_ff <= (addr_in == 4'h1) ? 16'h8000 :
                (addr_in == 4'h2) ? 16'h0020 : 16'h9fe0;
   end
   sequence s_rd(logic [3:0] a); rd_in && addr_in == a; endsequence
   sequence s_wr(logic [3:0] a); wr_in && addr_in == a; endsequence
   property p_alt_wr;
      s_wr(4'h0) |=> alt_vector_select_out == $past(wdata_in[15]);
   endproperty
   a_alt_wr: assert property (p_alt_wr)
      else $error("vector select does not follow write");
   property p_alt_hold;
      !(wr_in && addr_in == 4'h0) |=> $stable(alt_vector_select_out);
   endproperty
   a_alt_hold: assert property (p_alt_hold)
      else $error("vector select changed without write");
   property p_ctrl_status;
      s_rd(4'h0) |=> rdata_out[14] == $past(timed_irq_disable_active_in)
         && rdata_out[15] == $past(alt_vector_select_out);
   endproperty
   a_ctrl_status: assert property (p_ctrl_status)
      else $error("control read top bits wrong");
   property p_ctrl_rsv;
      s_rd(4'h0) |=> rdata_out[13:3] == 11'h0;
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv)
      else $error("control unimplemented bits not zero");
   property p_pol;
      s_wr(4'h0) ##1 !wr_in ##1 s_rd(4'h0)
         |=> rdata_out[2:0] == $past(wdata_in[2:0], 3);
   endproperty
   a_pol: assert property (p_pol)
      else $error("polarity bits not kept");
   property p_flag_rsv;
      rd_in && addr_in inside {4'h1, 4'h2, 4'h3}
         |=> (rdata_out & rsv_ff) == 16'h0;
   endproperty
   a_flag_rsv: assert property (p_flag_rsv)
      else $error("unimplemented flag bit reads one");
   property p_t1;
      timer1_req_in ##1 s_rd(4'h1) |=> rdata_out[3];
   endproperty
   a_t1: assert property (p_t1)
      else $error("timer flag not set by request");
   property p_reset;
      $fell(rst_in) |-> !alt_vector_select_out && rdata_out == 16'h0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
endmodule : ifcr_properties

// ### ifcr_src_model.sv
// Purpose: peripheral request sources and external pins
// Assumes: requests are one-cycle pulses, index = 16 * register + bit
// Notes:   pins move only when the bench asks
`timescale 1ns/10ps
module ifcr_src_model (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // bench commands
   input  wire logic [5:0]  src_sel_in,
   input  wire logic        src_go_in,
   input  wire logic [2:0]  pin_lvl_in,
   // towards the block
   output logic      [47:0] req_out,
   output logic      [2:0]  pin_out
);
   always_ff @(posedge mclk_in)
   begin
      req_out <= '0;
      if (!rst_in && src_go_in)
         req_out[src_sel_in] <= 1'b1;
      pin_out <= pin_lvl_in;
   end
endmodule : ifcr_src_model

// ### tb.sv
// Purpose: self-checking bench of the flag and control slice
// Assumes: 200 MHz clock, one copy with and one without CAN controller
// Notes:   sources and pins come from the partner model
`timescale 1ns/10ps
module tb
   import ifcr_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr_in = 4'h0;
   ifcr_word_t  wdata_in = 16'h0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        tdis = 1'b0;
   logic [5:0]  src_sel = 6'h0;
   logic        src_go = 1'b0;
   logic [2:0]  pin_lvl = 3'h0;
   logic        irq_seen = 1'b0;
   ifcr_word_t  rdata;
   ifcr_word_t  rdata_nc;
   ifcr_word_t  nc_seen = 16'h0;
   logic        alt;
   logic        irq;
   logic [47:0] rq;
   logic [2:0]  pins;
   int          bad_count = 0;
   int          compares = 0;
   initial forever #2.5 clk = ~clk;
   ifcr_src_model u_src (.mclk_in(clk), .rst_in(rst), .src_sel_in(src_sel),
      .src_go_in(src_go), .pin_lvl_in(pin_lvl), .req_out(rq), .pin_out(pins));
   ifcr_top u_dut (.mclk_in(clk), .rst_in(rst), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
      .timed_irq_disable_active_in(tdis), .alt_vector_select_out(alt),
      .irq_out(irq), .ext_irq_pin_in(pins),
      .capture1_req_in(rq[1]), .compare1_req_in(rq[2]),
      .timer1_req_in(rq[3]), .dma_ch0_done_req_in(rq[4]),
      .capture2_req_in(rq[5]), .compare2_req_in(rq[6]),
      .timer2_req_in(rq[7]), .timer3_req_in(rq[8]),
      .spi1_error_req_in(rq[9]), .spi1_event_req_in(rq[10]),
      .uart1_receive_req_in(rq[11]), .uart1_transmit_req_in(rq[12]),
      .adc1_done_req_in(rq[13]), .dma_ch1_done_req_in(rq[14]),
      .i2c1_slave_req_in(rq[16]), .i2c1_master_req_in(rq[17]),
      .comparator_req_in(rq[18]), .change_notify_req_in(rq[19]),
      .capture7_req_in(rq[22]), .capture8_req_in(rq[23]),
      .dma_ch2_done_req_in(rq[24]), .compare3_req_in(rq[25]),
      .compare4_req_in(rq[26]), .timer4_req_in(rq[27]),
      .timer5_req_in(rq[28]), .uart2_receive_req_in(rq[30]),
      .uart2_transmit_req_in(rq[31]), .spi2_error_req_in(rq[32]),
      .spi2_event_req_in(rq[33]), .can_receive_req_in(rq[34]),
      .can_event_req_in(rq[35]), .dma_ch3_done_req_in(rq[36]),
      .parallel_port_req_in(rq[45]), .dma_ch4_done_req_in(rq[46]));
   // second copy built without the CAN controller, same stimulus
   ifcr_top #(.CAN_PRESENT(1'b0)) u_dut_nc (.mclk_in(clk), .rst_in(rst),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_nc), .timed_irq_disable_active_in(tdis),
      .alt_vector_select_out(), .irq_out(), .ext_irq_pin_in(pins),
      .capture1_req_in(rq[1]), .compare1_req_in(rq[2]),
      .timer1_req_in(rq[3]), .dma_ch0_done_req_in(rq[4]),
      .capture2_req_in(rq[5]), .compare2_req_in(rq[6]),
      .timer2_req_in(rq[7]), .timer3_req_in(rq[8]),
      .spi1_error_req_in(rq[9]), .spi1_event_req_in(rq[10]),
      .uart1_receive_req_in(rq[11]), .uart1_transmit_req_in(rq[12]),
      .adc1_done_req_in(rq[13]), .dma_ch1_done_req_in(rq[14]),
      .i2c1_slave_req_in(rq[16]), .i2c1_master_req_in(rq[17]),
      .comparator_req_in(rq[18]), .change_notify_req_in(rq[19]),
      .capture7_req_in(rq[22]), .capture8_req_in(rq[23]),
      .dma_ch2_done_req_in(rq[24]), .compare3_req_in(rq[25]),
      .compare4_req_in(rq[26]), .timer4_req_in(rq[27]),
      .timer5_req_in(rq[28]), .uart2_receive_req_in(rq[30]),
      .uart2_transmit_req_in(rq[31]), .spi2_error_req_in(rq[32]),
      .spi2_event_req_in(rq[33]), .can_receive_req_in(rq[34]),
      .can_event_req_in(rq[35]), .dma_ch3_done_req_in(rq[36]),
      .parallel_port_req_in(rq[45]), .dma_ch4_done_req_in(rq[46]));
   task automatic chk(input ifcr_word_t got, input ifcr_word_t exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input ifcr_word_t d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk);
      wr_in <= 1'b0;
      @(posedge clk);
   endtask : wr
   // read data and irq are sampled once the answering edge has settled
   task automatic rd(input logic [3:0] a, input ifcr_word_t exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk);
      rd_in <= 1'b0;
      #1 chk(rdata, exp);
      irq_seen = irq;
      nc_seen = rdata_nc;
      @(posedge clk);
   endtask : rd
   task automatic fire(input logic [5:0] s);
      src_sel <= s;
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      @(posedge clk);
   endtask : fire
   task automatic t_ctrl;
      tdis <= 1'b1;
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'hc007);
      chk({15'h0, alt}, 16'h1);
      tdis <= 1'b0;
      wr(4'h0, 16'h4002);
      rd(4'h0, 16'h0002);
      chk({15'h0, alt}, 16'h0);
   endtask : t_ctrl
   task automatic t_sw;
      for (int r = 1; r < 4; r++)
         wr(4'(r), 16'hffff);
      rd(4'h1, 16'h7fff);
      rd(4'h2, 16'hffdf);
      rd(4'h3, 16'h601f);
      chk(nc_seen, 16'h6013);
      chk({15'h0, irq_seen}, 16'h0);
      wr(4'h6, 16'h4000);
      rd(4'h6, 16'h4000);
      chk({15'h0, irq_seen}, 16'h1);
      for (int r = 1; r < 4; r++)
         wr(4'(r), 16'h0);
      rd(4'h3, 16'h0);
      chk({15'h0, irq_seen}, 16'h0);
      wr(4'h6, 16'h0);
      src_sel <= 6'h3;
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      wr(4'h1, 16'h0);
      rd(4'h1, 16'h0008);
      wr(4'h8, 16'h0008);
   endtask : t_sw
   task automatic t_flags;
      ifcr_word_t m [3] = '{16'h7ffe, 16'hdfcf, 16'h601f};
      ifcr_word_t b;
      for (int r = 0; r < 3; r++)
      begin
         wr(4'(4 + r), 16'hffff);
         for (int i = 0; i < 16; i++)
         begin
            b = 16'h1 << i;
            if ((m[r] & b) != 16'h0)
            begin
               fire(6'(16 * r + i));
               rd(4'(1 + r), b);
               chk(nc_seen, (r == 2) ? (b & 16'h6013) : b);
               chk({15'h0, irq_seen}, 16'h1);
               wr(4'(8 + r), b);
               rd(4'(1 + r), 16'h0);
               chk({15'h0, irq_seen}, 16'h0);
            end
         end
         wr(4'(4 + r), 16'h0);
      end
   endtask : t_flags
   task automatic t_pins;
      wr(4'h0, 16'h0000);
      pin_lvl <= 3'h7;
      repeat (8) @(posedge clk);
      rd(4'h1, 16'h0001);
      rd(4'h2, 16'h2010);
      wr(4'h0, 16'h0007);
      repeat (8) @(posedge clk);
      wr(4'h1, 16'h0);
      wr(4'h2, 16'h0);
      pin_lvl <= 3'h0;
      repeat (8) @(posedge clk);
      rd(4'h1, 16'h0001);
      rd(4'h2, 16'h2010);
      wr(4'h1, 16'h0);
      wr(4'h2, 16'h0);
      pin_lvl <= 3'h7;
      repeat (8) @(posedge clk);
      rd(4'h1, 16'h0);
      rd(4'h2, 16'h0);
   endtask : t_pins
   // reset in mid-run with the pins held high must leave no false edge
   task automatic t_reset;
      wr(4'h0, 16'h8005);
      wr(4'h4, 16'h7fff);
      wr(4'h1, 16'h7fff);
      rd(4'h1, 16'h7fff);
      chk({15'h0, irq_seen}, 16'h1);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      rd(4'h0, 16'h0);
      chk({15'h0, alt}, 16'h0);
      rd(4'h1, 16'h0);
      chk({15'h0, irq_seen}, 16'h0);
      rd(4'h2, 16'h0);
      rd(4'h4, 16'h0);
   endtask : t_reset
   task automatic give_verdict;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 16; a++)
         rd(4'(a), 16'h0);
      t_ctrl();
      t_sw();
      t_flags();
      t_pins();
      t_reset();
      give_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule : tb
bind ifcr_top ifcr_properties u_props (.mclk_in(mclk_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out),
   .timed_irq_disable_active_in(timed_irq_disable_active_in),
   .alt_vector_select_out(alt_vector_select_out),
   .timer1_req_in(timer1_req_in));
